// *** dv/owd_detector_tb.sv ***
// Self-checking bench for the out-of-window event detector
`timescale 1ns/10ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module owd_detector_tb;
    import owd_pkg::*;
    logic aclk, aresetn, sample_valid, w, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, wake_timer_reset, irq;
    logic interrupt_pin_one, interrupt_pin_two;
    owd_sample_type sample;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata, d;
    logic [STRB_W-1:0] wstrb;
    logic [1:0] bresp, rresp, r;
    int n_mismatch = 0;
    int check_count = 0;
    owd_detector dut (.aclk, .aresetn, .sample_valid, .sample, .awvalid, .awready, .awaddr,
        .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
        .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata,
        .rresp, .interrupt_pin_one, .interrupt_pin_two, .wake_timer_reset, .irq);
    owd_host_model host (.aclk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
        .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
        .rdata, .rresp);
    initial aclk = 1'b0;
    always #5 aclk = ~aclk;
    // One sample set; w records any wake pulse after it
    task automatic smp(input logic [11:0] x, y, rx);
        sample <= {12'h000, y, x, 24'h000000, rx};
        sample_valid <= 1'b1;
        @(posedge aclk);
        sample_valid <= 1'b0;
        @(negedge aclk);
        w = wake_timer_reset;
        @(negedge aclk);
        w = w | wake_timer_reset;
        @(posedge aclk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Absolute mode, thresholds +100/-100, debounce 2, wake and pin one
    task automatic t_abs;
        host.rd(ADDR_SOURCE, d, r);
        `CHK("src_reset", 32'h00, d)
        host.wr(ADDR_CONFIG, 32'h67, r);
        host.wr(ADDR_THRESH, 32'h0F9C0064, r);
        host.wr(ADDR_DEBOUNCE, 32'h02, r);
        smp(12'h064, 12'hF9C, 12'h000);
        host.rd(ADDR_SOURCE, d, r);
        `CHK("src_first", 32'h00, d)
        smp(12'h064, 12'hF9C, 12'h000);
        `CHK("wake_on", 1'b1, w)
        host.rd(ADDR_SOURCE, d, r);
        `CHK("src_active", 32'hB8, d)
        `CHK("pin_one", 1'b1, interrupt_pin_one)
        `CHK("irq_masked", 1'b0, irq)
        host.wr(ADDR_IRQ_MASK, 32'h03, r);
        `CHK("irq_on", 1'b1, irq)
        host.rd(ADDR_IRQ_STATUS, d, r);
        `CHK("irq_status", 32'h03, d)
        `CHK("irq_clear", 1'b0, irq)
        smp(12'h063, 12'hF9D, 12'h000);
        `CHK("wake_off", 1'b0, w)
        host.rd(ADDR_SOURCE, d, r);
        `CHK("src_inside", 32'h10, d)
        $display("absolute test done");
    endtask
    // Relative mode, X only, latched, pin two, no debounce
    task automatic t_rel;
        host.wr(ADDR_CONFIG, 32'hD9, r);
        host.wr(ADDR_DEBOUNCE, 32'h00, r);
        smp(12'hFCE, 12'h0C8, 12'h03C);
        `CHK("pin_two", 1'b1, interrupt_pin_two)
        smp(12'h03C, 12'h0C8, 12'h03C);
        host.rd(ADDR_SOURCE, d, r);
        `CHK("src_latched", 32'h20, d)
        host.rd(ADDR_SOURCE, d, r);
        `CHK("src_cleared", 32'h00, d)
        $display("relative test done");
    endtask
    // Read-only write, unmapped read, threshold read-back
    task automatic t_bus;
        host.wr(ADDR_SOURCE, 32'hFF, r);
        `CHK("ro_resp", RESP_SLVERR, r)
        host.rd(8'h00, d, r);
        `CHK("unmapped", RESP_SLVERR, r)
        host.rd(ADDR_THRESH, d, r);
        `CHK("thresh", 32'h0F9C0064, d)
        host.wr(ADDR_CONFIG, 32'h00, r);
        smp(12'h064, 12'h064, 12'h000);
        host.rd(ADDR_SOURCE, d, r);
        `CHK("src_disabled", 32'h00, d)
        $display("bus test done");
    endtask
    // Counts and verdict
    task final_report;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial begin
        #100000;
        n_mismatch++;
        final_report;
    end
    // Main sequence
    initial begin
        aresetn = 1'b0;
        sample_valid = 1'b0;
        sample = '0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_abs;
        t_rel;
        t_bus;
        final_report;
    end
endmodule

// *** dv/owd_host_model.sv ***
// Host model: AXI4-Lite master that reaches the detector registers
`timescale 1ns/10ps
module owd_host_model
    import owd_pkg::*;
(
    // Clock
    input  wire logic              aclk,
    // Write channels
    output logic                   awvalid,
    input  wire logic              awready,
    output logic [ADDR_W-1:0]      awaddr,
    output logic                   wvalid,
    input  wire logic              wready,
    output logic [DATA_W-1:0]      wdata,
    output logic [STRB_W-1:0]      wstrb,
    input  wire logic              bvalid,
    output logic                   bready,
    input  wire logic [1:0]        bresp,
    // Read channels
    output logic                   arvalid,
    input  wire logic              arready,
    output logic [ADDR_W-1:0]      araddr,
    input  wire logic              rvalid,
    output logic                   rready,
    input  wire logic [DATA_W-1:0] rdata,
    input  wire logic [1:0]        rresp
);
    // Idle bus at time zero; full words only
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
    end
    ////////////////////////////////////////////////////////////////////////
    // Write: both channels offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic pa, pw, ta, tw;
        pa = 1'b1;
        pw = 1'b1;
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        while (pa || pw) begin
            @(negedge aclk);
            ta = pa && awready;
            tw = pw && wready;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        do begin
            @(negedge aclk);
            ta = bvalid;
            r = bresp;
            @(posedge aclk);
        end while (!ta);
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    // Read: a source read also clears latched flags in the device
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic t;
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(negedge aclk);
            t = arready;
            @(posedge aclk);
        end while (!t);
        arvalid <= 1'b0;
        do begin
            @(negedge aclk);
            t = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
        end while (!t);
        rready <= 1'b0;
        @(posedge aclk);
    endtask
endmodule

// *** hdl/owd_axis_compare.sv ***
// Window comparison of one axis against the two thresholds
`timescale 1ns/10ps
module owd_axis_compare
    import owd_pkg::*;
(
    // Axis data
    input  wire logic [SAMPLE_W-1:0] value,
    input  wire logic [SAMPLE_W-1:0] reference,
    // Settings
    input  wire logic                relative_mode,
    input  wire logic                enable,
    input  wire logic [SAMPLE_W-1:0] upper,
    input  wire logic [SAMPLE_W-1:0] lower,
    // Results
    output logic                     outside,
    output logic                     upper_hit
);
    logic signed [SAMPLE_W:0] operand;    // Sample or delta, one bit wider
    logic signed [SAMPLE_W:0] upper_ext;  // Sign-extended upper threshold
    logic signed [SAMPLE_W:0] lower_ext;  // Sign-extended lower threshold

    // Pick raw sample or delta, same compare either way
    always_comb begin
        upper_ext = $signed({upper[SAMPLE_W-1], upper});
        lower_ext = $signed({lower[SAMPLE_W-1], lower});
        if (relative_mode) begin
            operand = $signed({value[SAMPLE_W-1], value})
                    - $signed({reference[SAMPLE_W-1], reference});
        end else begin
            operand = $signed({value[SAMPLE_W-1], value});
        end
        upper_hit = enable && (operand >= upper_ext);
        outside   = enable && ((operand >= upper_ext) || (operand <= lower_ext));
    end

endmodule

// *** hdl/owd_detector.sv ***
// Out-of-window event detector with AXI4-Lite registers and interrupt
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// Function
// - Flag axis on or beyond either threshold
// - Flag zero strictly inside the window, unless latched
// - Polarity one upper, zero lower
// - Polarity captured when its flag sets
// - Active after debounce count consecutive samples
// - Active zero when all axes inside
// - Same compare on samples or deltas
// - Only enabled axes count; none disables
// - Reset sleep timer while active, if enabled
// - Unlatched flags update only once debounced
// - Active routable to either interrupt pin
module owd_detector
    import owd_pkg::*;
(
    // Clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // Sample stream, one set per output sample rate tick
    input  wire logic                sample_valid,
    input  wire owd_sample_type      sample,
    // AXI4-Lite write address
    input  wire logic                awvalid,
    output logic                     awready,
    input  wire logic [ADDR_W-1:0]   awaddr,
    input  wire logic [2:0]          awprot,
    // AXI4-Lite write data
    input  wire logic                wvalid,
    output logic                     wready,
    input  wire logic [DATA_W-1:0]   wdata,
    input  wire logic [STRB_W-1:0]   wstrb,
    // AXI4-Lite write response
    output logic                     bvalid,
    input  wire logic                bready,
    output logic [1:0]               bresp,
    // AXI4-Lite read address
    input  wire logic                arvalid,
    output logic                     arready,
    input  wire logic [ADDR_W-1:0]   araddr,
    input  wire logic [2:0]          arprot,
    // AXI4-Lite read data
    output logic                     rvalid,
    input  wire logic                rready,
    output logic [DATA_W-1:0]        rdata,
    output logic [1:0]               rresp,
    // Event outputs
    output logic                     interrupt_pin_one,
    output logic                     interrupt_pin_two,
    output logic                     wake_timer_reset,
    output logic                     irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    owd_config_type          config_reg;       // Enables and modes
    logic [SAMPLE_W-1:0]     upper_reg;        // Upper threshold
    logic [SAMPLE_W-1:0]     lower_reg;        // Lower threshold
    logic [DBCNT_W-1:0]      debounce_reg;     // Debounce count
    logic [IRQ_W-1:0]        irq_status_reg;   // Sticky event bits
    logic [IRQ_W-1:0]        irq_mask_reg;     // Interrupt mask
    logic [AXIS_COUNT-1:0]   flag_reg;         // Axis out-of-window flags
    logic [AXIS_COUNT-1:0]   flag_next;
    logic [AXIS_COUNT-1:0]   pol_reg;          // Axis polarity flags
    logic                    active_reg;       // Event active flag
    logic [DBCNT_W-1:0]      run_reg;          // Consecutive outside samples
    logic [DBCNT_W-1:0]      run_next;
    logic                    timer_reset_reg;  // Sleep timer reset pulse
    logic [AXIS_COUNT-1:0]   raw_outside;      // This sample outside
    logic [AXIS_COUNT-1:0]   raw_upper;        // This sample at or above upper
    logic                    any_raw;
    logic                    active_next;
    logic [IRQ_W-1:0]        irq_event;
    logic [7:0]              source_word;      // Source register image
    // Bus state
    logic                    aw_held_reg;
    logic [ADDR_W-1:0]       waddr_reg;
    logic                    w_held_reg;
    logic [DATA_W-1:0]       wdata_reg;
    logic [STRB_W-1:0]       wstrb_reg;
    logic                    bvalid_reg;
    logic [1:0]              bresp_reg;
    logic                    rvalid_reg;
    logic [DATA_W-1:0]       rdata_reg;
    logic [1:0]              rresp_reg;
    logic                    do_write;
    logic                    ar_fire;
    logic                    src_read;         // Read of source register taken
    logic                    irq_read;         // Read of interrupt status taken
    logic [DATA_W-1:0]       wr_mask;          // Byte enables as bit mask
    logic [DATA_W-1:0]       wr_merged;        // Old word with new bytes
    logic [DATA_W:0]         wr_lookup;        // Valid bit and old word
    logic [DATA_W:0]         rd_lookup;        // Valid bit and read word

    ////////////////////////////////////////////////////////////////////////////
    // Per-axis comparison
    generate
        for (genvar i = 0; i < AXIS_COUNT; i++) begin : g_axis
            owd_axis_compare u_cmp (
                .value         (sample.value[i]),
                .reference     (sample.reference[i]),
                .relative_mode (config_reg.relative_mode),
                .enable        (config_reg.axis_enable[i]),
                .upper         (upper_reg),
                .lower         (lower_reg),
                .outside       (raw_outside[i]),
                .upper_hit     (raw_upper[i])
            );
            // Polarity caught on the flag's rising edge only
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pol_reg[i] <= 1'b0;
                end else if (flag_next[i] && !flag_reg[i]) begin
                    pol_reg[i] <= raw_upper[i];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Debounce and event active
    always_comb begin
        any_raw = |raw_outside;
        if (!any_raw) begin
            run_next = '0;
        end else if (run_reg == RUN_MAX) begin
            run_next = run_reg;
        end else begin
            run_next = DBCNT_W'(run_reg + 8'h01);
        end
        active_next = any_raw && (run_next >= debounce_reg);
    end

    // Counter and active flag move once per sample
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_reg    <= '0;
            active_reg <= 1'b0;
        end else if (sample_valid) begin
            run_reg    <= run_next;
            active_reg <= active_next;
        end
    end

    // Axis flag next value; a new set beats a read clear
    always_comb begin
        flag_next = flag_reg;
        if (config_reg.out_window_latch_enable && src_read) begin
            flag_next = '0;
        end
        if (sample_valid) begin
            if (config_reg.out_window_latch_enable) begin
                if (active_next) begin
                    flag_next = flag_next | raw_outside;
                end
            end else if (!any_raw) begin
                flag_next = '0;
            end else if (active_next) begin
                flag_next = raw_outside;
            end
        end
    end

    // Axis flag storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_reg <= '0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // Sleep timer reset pulse for each sample that leaves active set;
    // the sample that clears active no longer holds the timer off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_reset_reg <= 1'b0;
        end else begin
            timer_reset_reg <= sample_valid && config_reg.wake_on_out_window
                               && active_next;
        end
    end

    // Pin routing of the event active flag
    always_comb begin
        interrupt_pin_one = config_reg.int_route_enable && !config_reg.int_pin_select
                            && active_reg;
        interrupt_pin_two = config_reg.int_route_enable && config_reg.int_pin_select
                            && active_reg;
        wake_timer_reset  = timer_reset_reg;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status, mask and output
    always_comb begin
        irq_event                 = '0;
        irq_event[IRQ_ACTIVE_BIT] = sample_valid && active_next && !active_reg;
        irq_event[IRQ_FLAG_BIT]   = |(flag_next & ~flag_reg);
        irq                       = |(irq_status_reg & irq_mask_reg);
    end

    // Sticky bits; read clears, a same-cycle event wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_reg <= '0;
        end else begin
            irq_status_reg <= (irq_read ? '0 : irq_status_reg) | irq_event;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register image lookup: valid bit above the word
    function automatic logic [DATA_W:0] lookup(input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] w;
        logic              ok;
        w  = '0;
        ok = 1'b1;
        unique case (a)
            ADDR_SOURCE:     w[7:0] = source_word;
            ADDR_CONFIG:     w[7:0] = config_reg;
            ADDR_THRESH: begin
                w[THRESH_UPPER_LSB +: SAMPLE_W] = upper_reg;
                w[THRESH_LOWER_LSB +: SAMPLE_W] = lower_reg;
            end
            ADDR_DEBOUNCE:   w[DBCNT_W-1:0] = debounce_reg;
            ADDR_IRQ_STATUS: w[IRQ_W-1:0]   = irq_status_reg;
            ADDR_IRQ_MASK:   w[IRQ_W-1:0]   = irq_mask_reg;
            default:         ok = 1'b0;
        endcase
        return {ok, w};
    endfunction

    // Source register image and bus decode
    always_comb begin
        source_word                 = '0;
        source_word[SRC_ACTIVE_BIT] = active_reg;
        for (int i = 0; i < AXIS_COUNT; i++) begin
            source_word[SRC_FLAG_X_BIT - SRC_AXIS_STEP * i]     = flag_reg[i];
            source_word[SRC_FLAG_X_BIT - SRC_AXIS_STEP * i - 1] = pol_reg[i];
        end
        for (int b = 0; b < STRB_W; b++) begin
            wr_mask[8*b +: 8] = {8{wstrb_reg[b]}};
        end
        rd_lookup = lookup(araddr);
        wr_lookup = lookup(waddr_reg);
        wr_merged = (wr_lookup[DATA_W-1:0] & ~wr_mask) | (wdata_reg & wr_mask);
        awready   = !aw_held_reg && !bvalid_reg;
        wready    = !w_held_reg && !bvalid_reg;
        arready   = !rvalid_reg;
        ar_fire   = arvalid && arready;
        src_read  = ar_fire && (araddr == ADDR_SOURCE);
        irq_read  = ar_fire && (araddr == ADDR_IRQ_STATUS);
        do_write  = aw_held_reg && w_held_reg && !bvalid_reg;
        bvalid    = bvalid_reg;
        bresp     = bresp_reg;
        rvalid    = rvalid_reg;
        rdata     = rdata_reg;
        rresp     = rresp_reg;
    end

    // Write address and data capture, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            waddr_reg   <= '0;
            wdata_reg   <= '0;
            wstrb_reg   <= '0;
        end else begin
            if (awvalid && awready) begin
                aw_held_reg <= 1'b1;
                waddr_reg   <= awaddr;
            end else if (do_write) begin
                aw_held_reg <= 1'b0;
            end
            if (wvalid && wready) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= wdata;
                wstrb_reg  <= wstrb;
            end else if (do_write) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // Register writes and write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            config_reg   <= owd_config_type'(CONFIG_RESET);
            upper_reg    <= UPPER_RESET;
            lower_reg    <= LOWER_RESET;
            debounce_reg <= DEBOUNCE_RESET;
            irq_mask_reg <= IRQ_MASK_RESET;
            bvalid_reg   <= 1'b0;
            bresp_reg    <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= RESP_OKAY;
            unique case (waddr_reg)
                ADDR_CONFIG:   config_reg   <= owd_config_type'(wr_merged[7:0]);
                ADDR_THRESH: begin
                    upper_reg <= wr_merged[THRESH_UPPER_LSB +: SAMPLE_W];
                    lower_reg <= wr_merged[THRESH_LOWER_LSB +: SAMPLE_W];
                end
                ADDR_DEBOUNCE: debounce_reg <= wr_merged[DBCNT_W-1:0];
                ADDR_IRQ_MASK: irq_mask_reg <= wr_merged[IRQ_W-1:0];
                // Read-only or unmapped
                default:       bresp_reg    <= RESP_SLVERR;
            endcase
        end else if (bvalid_reg && bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Read data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_lookup[DATA_W-1:0];
            rresp_reg  <= rd_lookup[DATA_W] ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_reg && rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_src_read;
        src_read ##1 rvalid;
    endsequence

    property p_flag_cause;
        $rose(flag_reg[0]) |-> $past(sample_valid && raw_outside[0]);
    endproperty
    a_flag_cause: assert property (p_flag_cause)
        else $error("X flag set without an outside sample");

    property p_inside_clear;
        sample_valid && !config_reg.out_window_latch_enable && !any_raw |=> flag_reg == 3'h0;
    endproperty
    a_inside_clear: assert property (p_inside_clear)
        else $error("Axis flag not cleared inside window");

    property p_pol_capture;
        $rose(flag_reg[1]) |-> pol_reg[1] == $past(raw_upper[1]);
    endproperty
    a_pol_capture: assert property (p_pol_capture)
        else $error("Y polarity not captured at flag set");

    property p_pol_hold;
        flag_reg[0] && $past(flag_reg[0]) |-> $stable(pol_reg[0]);
    endproperty
    a_pol_hold: assert property (p_pol_hold)
        else $error("X polarity changed while flag held");

    property p_debounce_set;
        sample_valid && any_raw && run_next >= debounce_reg |=> active_reg;
    endproperty
    a_debounce_set: assert property (p_debounce_set)
        else $error("Active not set after debounce");

    property p_inside_idle;
        sample_valid && !any_raw |=> !active_reg && run_reg == 8'h00;
    endproperty
    a_inside_idle: assert property (p_inside_idle)
        else $error("Active set with all axes inside");

    property p_disabled;
        sample_valid && config_reg.axis_enable == 3'h0 |=> !active_reg && run_reg == 8'h00;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("Detector active with all axes disabled");

    property p_wake_hold;
        sample_valid && config_reg.wake_on_out_window && active_next |=> wake_timer_reset;
    endproperty
    a_wake_hold: assert property (p_wake_hold)
        else $error("Sleep timer not reset while active");

    property p_unlatched_hold;
        sample_valid && !config_reg.out_window_latch_enable && any_raw && !active_next
            |=> $stable(flag_reg);
    endproperty
    a_unlatched_hold: assert property (p_unlatched_hold)
        else $error("Unlatched flags moved before debounce");

    property p_pin_route;
        $rose(active_reg) && config_reg.int_route_enable
            |-> (interrupt_pin_one != config_reg.int_pin_select)
                && (interrupt_pin_two == config_reg.int_pin_select);
    endproperty
    a_pin_route: assert property (p_pin_route)
        else $error("Event active not routed to selected pin");

    property p_latched_read;
        s_src_read |-> rdata[SRC_FLAG_X_BIT] == $past(flag_reg[0]);
    endproperty
    a_latched_read: assert property (p_latched_read)
        else $error("Source read returned wrong X flag");

endmodule

// *** hdl/owd_pkg.sv ***
// Shared constants and types for the out-of-window event detector
package owd_pkg;

    // Widths, fixed at the documented values
    localparam int SAMPLE_W   = 12;          // Axis sample width
    localparam int AXIS_COUNT = 3;           // X, Y, Z
    localparam int ADDR_W     = 8;           // AXI byte address width
    localparam int DATA_W     = 32;          // AXI data width
    localparam int STRB_W     = DATA_W / 8;  // Byte lanes
    localparam int DBCNT_W    = 8;           // Debounce count width
    localparam int IRQ_W      = 2;           // Interrupt status width

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_SOURCE     = 8'h2D;
    localparam logic [7:0] IDX_CONFIG     = 8'h30;
    localparam logic [7:0] IDX_THRESH     = 8'h31;
    localparam logic [7:0] IDX_DEBOUNCE   = 8'h32;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h33;
    localparam logic [7:0] IDX_IRQ_MASK   = 8'h34;

    // Byte addresses
    localparam logic [ADDR_W-1:0] ADDR_SOURCE     = {IDX_SOURCE[5:0], 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_CONFIG     = {IDX_CONFIG[5:0], 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_THRESH     = {IDX_THRESH[5:0], 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_DEBOUNCE   = {IDX_DEBOUNCE[5:0], 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS[5:0], 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK   = {IDX_IRQ_MASK[5:0], 2'b00};

    // Reset values
    localparam logic [7:0]          CONFIG_RESET   = 8'h00;
    localparam logic [SAMPLE_W-1:0] UPPER_RESET    = 12'h000;
    localparam logic [SAMPLE_W-1:0] LOWER_RESET    = 12'h000;
    localparam logic [DBCNT_W-1:0]  DEBOUNCE_RESET = 8'h00;
    localparam logic [IRQ_W-1:0]    IRQ_MASK_RESET = 2'h0;

    // Source register field positions
    localparam int SRC_ACTIVE_BIT = 7;       // Event active flag
    localparam int SRC_FLAG_X_BIT = 5;       // Axis i flag at 5-2i, polarity one below
    localparam int SRC_AXIS_STEP  = 2;

    // Threshold register field positions
    localparam int THRESH_UPPER_LSB = 0;
    localparam int THRESH_LOWER_LSB = 16;

    // Interrupt status bits
    localparam int IRQ_ACTIVE_BIT = 0;       // Event active rose
    localparam int IRQ_FLAG_BIT   = 1;       // An axis flag became set

    // Counter ceiling and bus answers
    localparam logic [DBCNT_W-1:0] RUN_MAX     = 8'hFF;
    localparam logic [1:0]         RESP_OKAY   = 2'h0;
    localparam logic [1:0]         RESP_SLVERR = 2'h2;

    // Configuration register layout, bit 0 first from the right
    typedef struct packed {
        logic       int_pin_select;           // 0 pin one, 1 pin two
        logic       int_route_enable;         // Route event active to a pin
        logic       wake_on_out_window;       // Hold off the sleep timer
        logic       relative_mode;            // Compare deltas, not samples
        logic       out_window_latch_enable;  // Sticky axis flags
        logic [2:0] axis_enable;              // Z, Y, X enables
    } owd_config_type;

    // One sample set with its reference, index 0 is X
    typedef struct packed {
        logic [AXIS_COUNT-1:0][SAMPLE_W-1:0] value;
        logic [AXIS_COUNT-1:0][SAMPLE_W-1:0] reference;
    } owd_sample_type;

endpackage
